// File: inc/pwm_map.svh
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH

// ----------------------------------------
// control latch layout
// ----------------------------------------
`define CTRL_DT_LSB 0
`define CTRL_DT_MSB 2
`define CTRL_RSVD_BIT 3
`define CTRL_LOCK_BIT 4
`define CTRL_DIV_BIT 5
`define CTRL_RES_BIT 6
`define CTRL_RUN_BIT 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RESET 8'h47
`define PW_RESET 8'h00

// ----------------------------------------
// latch select codes
// ----------------------------------------
`define SEL_PULSE_WIDTH 1'b0
`define SEL_CONTROL 1'b1

// ----------------------------------------
// timing counts
// ----------------------------------------
`define PERIOD_8BIT 256
`define PERIOD_7BIT 128
`define TOP_8BIT 8'hff
`define TOP_7BIT 8'h7f
`define DT_CLKS_PER_CODE 2
`define CODE_FULL_8BIT 8'hff
`define CODE_FULL_7BIT 7'h7f
`define CODE_NONE_8BIT 8'h01

`endif

// File: inc/pwm_pkg.sv
`default_nettype none
package pwm_pkg;

    // control latch as stored
    typedef struct packed {
        logic run;
        logic res8;
        logic div2;
        logic lock;
        logic rsvd;
        logic [2:0] deadtime_code;
    } ctrl_t;

    // parallel write bus pins
    typedef struct packed {
        logic dev_sel_n;
        logic latch_sel;
        logic wr_n;
        logic [7:0] data;
    } bus_wr_t;

    // the two bridge drive outputs
    typedef struct packed {
        logic phase_a_output;
        logic phase_b_output;
    } phase_out_t;

endpackage
`default_nettype wire

// File: rtl/bus_loaded_dual_pwm_core.sv
// Operation
// - reset selects 8-bit resolution.
// - period is 256 pwm clocks in 8-bit mode, 128 in 7-bit mode.
// - pwm clock is one external clock, or two when halving bit is one.
// - pulse width code sets phase a high time, phase b low time.
// - each output's high time shortened by one dead-time, both low then.
// - run bit zero forces both outputs low at once and holds them low.
// - run bit stays writable while freeze bit is set.
// - shutdown pin acts like run bit; resume only at period start with both one.
// - resolution bit picks 7 or 8 significant code bits for the compare.
// - duty is code over 128 (7-bit) or over 256 (8-bit).
// - 8-bit codes 0,1 give 0%, ff gives 100%; 7-bit 7f or top bit give 100%.
// - code writes any time; while disabled outputs stay low and unchanged.
// - on re-enable the latest written code drives the waveform.
// - select low plus strobe loads data into width or control latch.
// - dead-time is twice the 3-bit code in external clocks, halving ignored.
// - freeze bit locks control bits 0 to 6; only reset clears it.
// - control layout: dead-time 0-2, freeze 4, halve 5, resolution 6, run 7.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_map.svh"

module bus_loaded_dual_pwm_core
    import pwm_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int DT_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire bus_wr_t bus_i,
    input wire logic shutdown_pin_n_i,
    output var phase_out_t phase_o
);

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire logic wr_hit;
    wire logic pw_wr;
    wire logic ctrl_wr;

    assign wr_hit = !bus_i.dev_sel_n && !bus_i.wr_n;
    assign pw_wr = wr_hit && (bus_i.latch_sel == `SEL_PULSE_WIDTH);
    assign ctrl_wr = wr_hit && (bus_i.latch_sel == `SEL_CONTROL);

    // ----------------------------------------
    // latches
    // ----------------------------------------
    logic [7:0] pulse_width_latch_q;
    logic [7:0] pulse_width_latch_d;
    ctrl_t ctrl_q;
    ctrl_t ctrl_d;
    wire ctrl_t ctrl_wdata;

    // reserved bit is never stored, it always holds zero
    assign ctrl_wdata = ctrl_t'(bus_i.data & ~(8'h01 << `CTRL_RSVD_BIT));

    // width latch is writable at any moment, enabled or not
    assign pulse_width_latch_d = pw_wr ? bus_i.data : pulse_width_latch_q;

    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d.run = ctrl_wdata.run;
            if (!ctrl_q.lock) begin
                ctrl_d = ctrl_wdata;
            end
        end
    end

    // reset is the only way to clear the freeze bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pulse_width_latch_q <= `PW_RESET;
            ctrl_q <= ctrl_t'(`CTRL_RESET);
        end else begin
            pulse_width_latch_q <= pulse_width_latch_d;
            ctrl_q <= ctrl_d;
        end
    end

    // ----------------------------------------
    // pwm clock and period counter
    // ----------------------------------------
    logic half_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire logic pwm_tick;
    wire logic [CNT_W-1:0] cnt_top;
    wire logic at_top;
    wire logic period_start;

    // halving only slows the counter, the dead-time counter keeps full rate
    assign pwm_tick = !ctrl_q.div2 || half_q;
    assign cnt_top = ctrl_q.res8 ? CNT_W'(`TOP_8BIT) : CNT_W'(`TOP_7BIT);
    assign at_top = (cnt_q >= cnt_top);
    assign period_start = pwm_tick && at_top;
    assign cnt_d = !pwm_tick ? cnt_q :
                   at_top ? '0 :
                   cnt_q + CNT_W'(1);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            half_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            half_q <= !half_q;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // comparator
    // ----------------------------------------
    // compare uses the live latch, so a new code acts mid-period
    // extremes are forced flat, so no edge and no dead-time at 0% or 100%
    function automatic logic phase_a_level(input logic [7:0] code,
                                           input logic [CNT_W-1:0] cnt,
                                           input logic res8);
        logic lvl;
        lvl = 1'b0;
        if (res8) begin
            if (code == `CODE_FULL_8BIT) begin
                lvl = 1'b1;
            end else if (code <= `CODE_NONE_8BIT) begin
                lvl = 1'b0;
            end else begin
                lvl = (cnt < CNT_W'(code));
            end
        end else begin
            if (code[7] || (code[6:0] == `CODE_FULL_7BIT)) begin
                lvl = 1'b1;
            end else begin
                lvl = (cnt < CNT_W'(code[6:0]));
            end
        end
        return lvl;
    endfunction

    wire logic raw_a;
    logic raw_a_q;

    assign raw_a = phase_a_level(pulse_width_latch_q, cnt_q, ctrl_q.res8);

    // ----------------------------------------
    // dead-time
    // ----------------------------------------
    // reloaded on every comparator edge; an on-time no longer than the
    // dead-time therefore never turns its output on
    logic [DT_W-1:0] dt_q;
    logic [DT_W-1:0] dt_d;
    wire logic raw_edge;
    wire logic [DT_W-1:0] dt_load;

    assign raw_edge = (raw_a != raw_a_q);
    assign dt_load = DT_W'(ctrl_q.deadtime_code) * DT_W'(`DT_CLKS_PER_CODE);
    assign dt_d = raw_edge ? dt_load :
                  (dt_q != '0) ? dt_q - DT_W'(1) :
                  dt_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raw_a_q <= 1'b0;
            dt_q <= '0;
        end else begin
            raw_a_q <= raw_a;
            dt_q <= dt_d;
        end
    end

    // ----------------------------------------
    // output enable
    // ----------------------------------------
    wire logic off_req;
    logic en_q;
    logic en_d;
    logic start_q;

    // either source drops the enable without waiting for the period
    assign off_req = !ctrl_q.run || !shutdown_pin_n_i;
    // comparator is one flop behind the counter, so the enable waits a clock
    // too; otherwise a stale level of the old period leaks out first
    assign en_d = off_req ? 1'b0 :
                  start_q ? 1'b1 :
                  en_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            en_q <= en_d;
            start_q <= period_start;
        end
    end

    // ----------------------------------------
    // output stage
    // ----------------------------------------
    wire logic live;
    wire logic dt_idle;
    phase_out_t phase_d;

    // one flop per pin, so a disable shows at the pins one clock later
    assign live = en_q && !off_req;
    assign dt_idle = (dt_q == '0);
    assign phase_d.phase_a_output = live && raw_a_q && dt_idle;
    assign phase_d.phase_b_output = live && !raw_a_q && dt_idle;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_o <= '0;
        end else begin
            phase_o <= phase_d;
        end
    end

endmodule

`default_nettype wire

// File: test/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
    import pwm_pkg::*;
(
    input wire logic clk_i,
    output var bus_wr_t bus_o
);
    // ------
    // write-only host
    // ------
    initial bus_o <= {1'b1, 1'b0, 1'b1, 8'h00};
    // strobe held over one edge; released data inverted, not left stale
    task automatic wr(input logic cs_n, input logic sel, input logic [7:0] d);
        @(posedge clk_i) #2;
        bus_o <= {cs_n, sel, 1'b0, sel ? d & 8'hf7 : d};
        @(posedge clk_i) #2;
        bus_o <= {1'b1, sel, 1'b1, ~d};
    endtask
endmodule
`default_nettype wire

// File: test/pwm_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwm_map.svh"
module pwm_core_checker
    import pwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire bus_wr_t bus_i,
    input wire logic shutdown_pin_n_i,
    input wire phase_out_t phase_o
);
    // ------
    // shadow latches
    // ------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [7:0] ctrl_q;
    logic [7:0] pw_q;
    wire wr = !bus_i.dev_sel_n && !bus_i.wr_n;
    wire a = phase_o.phase_a_output;
    wire b = phase_o.phase_b_output;
    wire on = ctrl_q[7] && shutdown_pin_n_i;
    wire [2:0] dt = ctrl_q[2:0];
    wire full = ctrl_q[6] ? pw_q == 8'hff : (pw_q[7] || pw_q == 8'h7f);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `CTRL_RESET;
            pw_q <= `PW_RESET;
        end else if (wr && bus_i.latch_sel) begin
            ctrl_q <= ctrl_q[4] ? {bus_i.data[7], ctrl_q[6:0]} : bus_i.data & 8'hf7;
        end else if (wr) begin
            pw_q <= bus_i.data;
        end
    end
    // three cycles allow for the registered disable path
    property p_no_overlap; !(a && b); endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("phases overlap");
    property p_run_off; (!ctrl_q[7]) [*3] |-> !a && !b; endproperty
    a_run_off: assert property (p_run_off) else $error("run off not low");
    property p_pin_off; (!shutdown_pin_n_i) [*3] |-> !a && !b; endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin off not low");
    property p_dead_a; $fell(a) && $past(dt) != 0 |-> !b ##1 !b; endproperty
    a_dead_a: assert property (p_dead_a) else $error("no gap after a");
    property p_dead_b; $fell(b) && $past(dt) != 0 |-> !a ##1 !a; endproperty
    a_dead_b: assert property (p_dead_b) else $error("no gap after b");
    property p_no_gap; a && dt == 0 ##1 on |-> a || b; endproperty
    a_no_gap: assert property (p_no_gap) else $error("gap at zero code");
    property p_zero; (ctrl_q[6] && pw_q <= 8'h01) [*3] |-> !a; endproperty
    a_zero: assert property (p_zero) else $error("zero code drives a");
    property p_full; full [*3] |-> !b; endproperty
    a_full: assert property (p_full) else $error("full code drives b");
endmodule
bind bus_loaded_dual_pwm_core pwm_core_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus_i(bus_i), .shutdown_pin_n_i(shutdown_pin_n_i), .phase_o(phase_o));
`default_nettype wire

// File: test/bus_loaded_dual_pwm_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bus_loaded_dual_pwm_core_tb
    import pwm_pkg::*;
;
    // ------
    // bench
    // ------
    typedef struct {logic [7:0] c; logic [7:0] p; int w; int na; int nb;} row_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic pin_n = 1'b1;
    bus_wr_t bus;
    phase_out_t ph;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    row_t rows[8] = '{'{8'h80, 8'h40, 128, 64, 64}, '{8'hc0, 8'h03, 256, 3, 253},
        '{8'hc0, 8'h01, 256, 0, 256}, '{8'hc0, 8'hff, 256, 256, 0},
        '{8'h80, 8'h90, 128, 128, 0}, '{8'ha0, 8'h20, 256, 64, 192},
        '{8'he0, 8'h80, 512, 256, 256}, '{8'he3, 8'h80, 512, 250, 250}};
    always #20 clk_i = ~clk_i;
    host_bus_model host (.clk_i(clk_i), .bus_o(bus));
    bus_loaded_dual_pwm_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
        .shutdown_pin_n_i(pin_n), .phase_o(ph));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0d seen %0d", n, exp, got);
        end
    endtask
    // counting over one full period makes the window phase irrelevant
    task automatic meas(input int w, output logic [15:0] na, output logic [15:0] nb);
        na = 0;
        nb = 0;
        repeat (w) begin
            @(posedge clk_i) #1;
            na += ph.phase_a_output;
            nb += ph.phase_b_output;
        end
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        logic [15:0] na;
        logic [15:0] nb;
        repeat (8) @(posedge clk_i);
        #2 rst_n_i = 1'b1;
        meas(300, na, nb);
        chk("reset idle", na + nb, 16'h0000);
        foreach (rows[i]) begin
            host.wr(1'b0, 1'b1, rows[i].c);
            host.wr(1'b0, 1'b0, rows[i].p);
            repeat (600) @(posedge clk_i);
            meas(rows[i].w, na, nb);
            chk("duty a", na, 16'(rows[i].na));
            chk("duty b", nb, 16'(rows[i].nb));
        end
        host.wr(1'b0, 1'b1, 8'h80);
        host.wr(1'b0, 1'b0, 8'h40);
        @(posedge clk_i) #2 pin_n = 1'b0;
        repeat (3) @(posedge clk_i);
        host.wr(1'b0, 1'b0, 8'h20);
        meas(300, na, nb);
        chk("pin off", na + nb, 16'h0000);
        @(posedge clk_i) #2 pin_n = 1'b1;
        repeat (200) @(posedge clk_i);
        meas(128, na, nb);
        chk("resume a", na, 16'h0020);
        chk("resume b", nb, 16'h0060);
        host.wr(1'b0, 1'b1, 8'hd0);
        host.wr(1'b0, 1'b0, 8'h80);
        host.wr(1'b0, 1'b1, 8'h23);
        meas(300, na, nb);
        chk("stop locked", na + nb, 16'h0000);
        host.wr(1'b0, 1'b1, 8'h80);
        host.wr(1'b1, 1'b1, 8'h00);
        repeat (600) @(posedge clk_i);
        meas(256, na, nb);
        chk("locked a", na, 16'h0080);
        chk("locked b", nb, 16'h0080);
        @(posedge clk_i) #2 rst_n_i = 1'b0;
        #1 chk("reset out", 16'(ph), 16'h0000);
        repeat (3) @(posedge clk_i);
        #2 rst_n_i = 1'b1;
        meas(300, na, nb);
        chk("reset idle again", na + nb, 16'h0000);
        host.wr(1'b0, 1'b1, 8'h80);
        repeat (300) @(posedge clk_i);
        meas(256, na, nb);
        chk("cleared width a", na, 16'h0000);
        chk("cleared width b", nb, 16'h0100);
        host.wr(1'b0, 1'b0, 8'h40);
        repeat (300) @(posedge clk_i);
        meas(256, na, nb);
        chk("unlocked a", na, 16'h0080);
        tally_and_finish();
    end
endmodule
`default_nettype wire
